// [design/odp_dictionary.sv]
`timescale 1ns/1ps
`include "odp_map.svh"
module odp_dictionary #(
   // Identification values are arbitrary
   parameter logic [31:0] VENDOR_CODE = 32'h0000_0123,
   parameter logic [31:0] PRODUCT_CODE = 32'h0000_0456,
   parameter logic [15:0] REV_MAJOR = 16'h0001,
   parameter logic [15:0] REV_MINOR = 16'h0000,
   parameter int HIST_DEPTH = `ODP_HIST_DEPTH
) (
   input wire logic CORE_CLK,
   input wire logic RSTN,
   input odp_pkg::odp_req_s REQ,
   output odp_pkg::odp_rsp_s RSP,
   input wire logic SERVO_ON,
   input wire logic [3:0] NET_STATE,
   input wire logic [7:0] ERR_FLAGS,
   input odp_pkg::odp_alarm_s ALARM,
   input odp_pkg::odp_params_t NV_PARAMS_IN,
   output logic NV_STORE,
   output odp_pkg::odp_params_t NV_PARAMS_OUT,
   output logic [7:0] ERR_SUMMARY
);
   import odp_pkg::*;

   localparam logic [23:0] SAVE_KEY [`ODP_SAVE_NUM] = `ODP_SAVE_KEYS;
   localparam logic [7:0] MAP_CNT [8] = '{8'h02, 8'h02, 8'h04, 8'h01,
      8'h03, 8'h03, 8'h08, 8'h01};
   localparam odp_ents_t MAP_DEF [8] = '{
      {192'h0, `ODP_E_RTPOS, `ODP_E_RCTL},
      {192'h0, `ODP_E_RTPOS, `ODP_E_RCTL},
      {128'h0, `ODP_E_RDOUT, `ODP_E_RPRB, `ODP_E_RTPOS, `ODP_E_RCTL},
      {224'h0, `ODP_E_RCTL},
      {160'h0, `ODP_E_TTRQ, `ODP_E_TVEL, `ODP_E_TSTS},
      {160'h0, `ODP_E_TTRQ, `ODP_E_TVEL, `ODP_E_TSTS},
      {`ODP_E_TDIN, `ODP_E_TPP2, `ODP_E_TPP1, `ODP_E_TPST,
       `ODP_E_TERR, `ODP_E_TTRQ, `ODP_E_TPOS, `ODP_E_TSTS},
      {224'h0, `ODP_E_TSTS}};

   ////////////////////////////////////////////////////////////////
   // State
   odp_phase_e phase_reg;
   odp_phase_e phase_next;
   logic servo_s1_reg;
   logic servo_s2_reg;
   odp_rsp_s rsp_reg;
   odp_rsp_s rsp_next;
   logic store_reg;
   odp_params_t nv_out_reg;
   odp_params_t params_reg;
   odp_params_t params_next;
   logic [7:0] errsum_reg;
   logic [31:0] hist_reg [HIST_DEPTH];
   logic [3:0] hist_cnt_reg;
   logic [3:0] hist_cnt_next;

   ////////////////////////////////////////////////////////////////
   // Decode
   logic rd_req;
   logic wr_req;
   logic sub_zero;
   logic hit_devtype;
   logic hit_errsum;
   logic hit_hist;
   logic hit_store;
   logic hit_ident;
   logic hit_rxmap;
   logic hit_txmap;
   logic hit_map;
   logic [2:0] map_num;
   logic [`ODP_SAVE_NUM-1:0] hit_save;
   logic hit_any_save;
   logic [2:0] save_idx;
   logic preop;
   logic sig_ok;
   logic store_wr;
   logic store_go;
   logic alarm_take;
   logic [2:0] hist_sel;
   logic [31:0] map_rdata [8];
   logic [31:0] map_code [8];
   logic [31:0] rd_data;
   logic [31:0] ab_code;

   assign rd_req = REQ.valid && !REQ.write;
   assign wr_req = REQ.valid && REQ.write;
   assign sub_zero = REQ.sub == 8'h00;
   assign hit_devtype = REQ.index == `ODP_IDX_DEVTYPE;
   assign hit_errsum = REQ.index == `ODP_IDX_ERRSUM;
   assign hit_hist = REQ.index == `ODP_IDX_HIST;
   assign hit_store = REQ.index == `ODP_IDX_STORE;
   assign hit_ident = REQ.index == `ODP_IDX_IDENT;
   // four receive and four transmit objects
   assign hit_rxmap = {REQ.index[15:2], 2'b00} == `ODP_IDX_RXMAP;
   assign hit_txmap = {REQ.index[15:2], 2'b00} == `ODP_IDX_TXMAP;
   assign hit_map = hit_rxmap || hit_txmap;
   assign map_num = {hit_txmap, REQ.index[1:0]};
   assign preop = NET_STATE == `ODP_ESM_PREOP;
   assign hist_sel = 3'(REQ.sub - 8'h01);

   genvar g;
   generate
      for (g = 0; g < `ODP_SAVE_NUM; g++) begin : g_save
         assign hit_save[g] = {REQ.index, REQ.sub} == SAVE_KEY[g];
      end
   endgenerate
   assign hit_any_save = |hit_save;
   always_comb begin
      save_idx = 3'h0;
      for (int i = 0; i < `ODP_SAVE_NUM; i++) begin
         if (hit_save[i])
            save_idx = 3'(i);
      end
   end

   // signature compare on store subindex 3
   assign sig_ok = REQ.wdata == `ODP_SAVE_SIG;
   assign store_wr = wr_req && hit_store && REQ.sub == `ODP_SUB_SAVE;
   // no save while the motor is powered
   assign store_go = store_wr && sig_ok && !servo_s2_reg;
   // only alarms while powered are recorded
   assign alarm_take = ALARM.valid && servo_s2_reg;

   ////////////////////////////////////////////////////////////////
   // Mapping objects
   generate
      for (g = 0; g < 8; g++) begin : g_map
         odp_pdo_map #(
            .DEF_CNT(MAP_CNT[g]),
            .DEF_ENT(MAP_DEF[g])
         ) u_map (
            .clk(CORE_CLK),
            .rstn(RSTN),
            .sel(REQ.valid && hit_map && map_num == 3'(g)),
            .write(REQ.write),
            .preop(preop),
            .sub(REQ.sub),
            .wdata(REQ.wdata),
            .rdata(map_rdata[g]),
            .code(map_code[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////
   // Read mux and abort selection
   always_comb begin
      rd_data = 32'h0000_0000;
      ab_code = `ODP_AB_NOOBJ;
      if (hit_devtype) begin
         rd_data = `ODP_DEVTYPE_VAL;
         ab_code = !sub_zero ? `ODP_AB_NOSUB :
                   REQ.write ? `ODP_AB_RO : 32'h0000_0000;
      end else if (hit_errsum) begin
         rd_data = {24'h000000, errsum_reg};
         ab_code = !sub_zero ? `ODP_AB_NOSUB :
                   REQ.write ? `ODP_AB_RO : 32'h0000_0000;
      end else if (hit_hist) begin
         rd_data = sub_zero ? {28'h0000000, hist_cnt_reg} :
                   hist_reg[hist_sel];
         ab_code = REQ.sub > 8'(HIST_DEPTH) ? `ODP_AB_NOSUB :
                   REQ.write ? `ODP_AB_RO : 32'h0000_0000;
      end else if (hit_store) begin
         rd_data = REQ.sub == `ODP_SUB_SAVE ? `ODP_STORE_CAPS :
                   sub_zero ? 32'(`ODP_SUB_SAVE) : 32'h0000_0000;
         ab_code = REQ.sub > `ODP_SUB_SAVE ? `ODP_AB_NOSUB :
                   !REQ.write ? 32'h0000_0000 :
                   REQ.sub != `ODP_SUB_SAVE ? `ODP_AB_RO :
                   !sig_ok ? `ODP_AB_STORE :
                   servo_s2_reg ? `ODP_AB_STATE : 32'h0000_0000;
      end else if (hit_ident) begin
         case (REQ.sub)
            8'h00: rd_data = `ODP_IDENT_CNT;
            8'h01: rd_data = VENDOR_CODE;
            8'h02: rd_data = PRODUCT_CODE;
            8'h03: rd_data = {REV_MAJOR, REV_MINOR};
            default: rd_data = 32'h0000_0000;
         endcase
         ab_code = REQ.sub > `ODP_SUB_IDMAX ? `ODP_AB_NOSUB :
                   REQ.write ? `ODP_AB_RO : 32'h0000_0000;
      end else if (hit_map) begin
         rd_data = map_rdata[map_num];
         ab_code = map_code[map_num];
      end else if (hit_any_save) begin
         rd_data = params_reg[save_idx];
         ab_code = 32'h0000_0000;
      end
   end

   always_comb begin
      rsp_next.valid = REQ.valid;
      rsp_next.abort = REQ.valid && ab_code != 32'h0000_0000;
      if (!REQ.valid || REQ.write)
         rsp_next.data = rsp_next.abort ? ab_code : 32'h0000_0000;
      else
         rsp_next.data = rsp_next.abort ? ab_code : rd_data;
   end

   ////////////////////////////////////////////////////////////////
   // Saved objects
   always_comb begin
      params_next = params_reg;
      phase_next = phase_reg;
      case (phase_reg)
         ST_LOAD: begin
            params_next = NV_PARAMS_IN;
            phase_next = ST_RUN;
         end
         ST_RUN: begin
            if (wr_req && hit_any_save)
               params_next[save_idx] = REQ.wdata;
         end
         default: phase_next = ST_LOAD;
      endcase
   end

   assign hist_cnt_next = (alarm_take && hist_cnt_reg < 4'(HIST_DEPTH)) ?
      hist_cnt_reg + 4'h1 : hist_cnt_reg;

   ////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge CORE_CLK) begin
      // Motor power comes from a pin, so it is synchronised
      servo_s1_reg <= SERVO_ON;
      servo_s2_reg <= servo_s1_reg;
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
         phase_reg <= ST_LOAD;
         params_reg <= '0;
         rsp_reg <= '0;
      end else begin
         phase_reg <= phase_next;
         params_reg <= params_next;
         rsp_reg <= rsp_next;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
         store_reg <= 1'b0;
         nv_out_reg <= '0;
      end else begin
         store_reg <= store_go;
         if (store_go)
            nv_out_reg <= params_reg;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RSTN)
         errsum_reg <= 8'h00;
      else
         errsum_reg <= ERR_FLAGS & `ODP_ERRSUM_MASK;
   end

   // alarm low half, emergency code high half
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
         hist_cnt_reg <= 4'h0;
         for (int i = 0; i < HIST_DEPTH; i++)
            hist_reg[i] <= 32'h0000_0000;
      end else begin
         hist_cnt_reg <= hist_cnt_next;
         if (alarm_take) begin
            hist_reg[0] <= {ALARM.emcy, ALARM.alarm};
            for (int i = 1; i < HIST_DEPTH; i++)
               hist_reg[i] <= hist_reg[i-1];
         end
      end
   end

   assign RSP = rsp_reg;
   assign NV_STORE = store_reg;
   assign NV_PARAMS_OUT = nv_out_reg;
   assign ERR_SUMMARY = errsum_reg;

   ////////////////////////////////////////////////////////////////
   // Checks
   a_rsp_timing: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      REQ.valid |=> RSP.valid ##1 !RSP.valid || $past(REQ.valid))
      else $error("answer not one cycle after request");
   a_save_sig: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      store_wr && sig_ok && !servo_s2_reg |=>
         NV_STORE && !RSP.abort && NV_PARAMS_OUT == $past(params_reg))
      else $error("signature write did not store");
   a_save_blocked: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      store_wr && servo_s2_reg |=> !NV_STORE && RSP.abort)
      else $error("save performed while motor powered");
   a_errsum_bit6: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      $past(RSTN) |-> !ERR_SUMMARY[6] &&
         (ERR_SUMMARY[5:0] == $past(ERR_FLAGS[5:0])))
      else $error("error summary wrong");
   a_hist_count: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      alarm_take && hist_cnt_reg < 4'h8 |=>
         hist_cnt_reg == $past(hist_cnt_reg) + 4'h1)
      else $error("history count did not advance");
   a_hist_entry: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      alarm_take |=> hist_reg[0] == {$past(ALARM.emcy), $past(ALARM.alarm)})
      else $error("history entry layout wrong");
   a_caps_read: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      rd_req && hit_store && REQ.sub == `ODP_SUB_SAVE |=>
         RSP.data == `ODP_STORE_CAPS)
      else $error("store capability read wrong");
   a_serial_zero: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      rd_req && hit_ident && REQ.sub == `ODP_SUB_IDMAX |=>
         !RSP.abort && RSP.data == 32'h0000_0000)
      else $error("serial number not zero");
   a_map_state: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      wr_req && hit_map && !preop && REQ.sub <= 8'h08 |=>
         RSP.abort && RSP.data == `ODP_AB_STATE)
      else $error("mapping write outside pre-op not aborted");
   a_load_start: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      phase_reg == ST_LOAD |=> params_reg == $past(NV_PARAMS_IN))
      else $error("startup load missed");
   c_save_done: cover property (@(posedge CORE_CLK) disable iff (!RSTN)
      NV_STORE);
   c_map_abort: cover property (@(posedge CORE_CLK) disable iff (!RSTN)
      RSP.abort && RSP.data == `ODP_AB_LEN);
   c_hist_full: cover property (@(posedge CORE_CLK) disable iff (!RSTN)
      hist_cnt_reg == 4'h8);
endmodule

// [design/odp_map.svh]
// Behaviour
// - Eight-bit read-only error summary, bit 6 zero
// - Read-only error history, at most eight entries
// - History entry: alarm low, emergency code high
// - Writing 'save' signature stores saveable objects
// - Saved parameters load into objects at startup
// - Save refused while the motor is powered
// - Store subindex 3 reads one capability bit, bit 1
// - Seven homing and gear objects are saved
// - Revision holds major and minor version fields
// - Identity serial number always reads zero
// - Mapping entry: length, subindex, object index
// - Mapping changes only in pre-operational state
// - Four receive and four transmit mapping objects
// - Eight entries and 32 bytes per mapping
`ifndef ODP_MAP_SVH
`define ODP_MAP_SVH

`define ODP_IDX_DEVTYPE 16'h1000
`define ODP_IDX_ERRSUM 16'h1001
`define ODP_IDX_HIST 16'h1003
`define ODP_IDX_STORE 16'h1010
`define ODP_IDX_IDENT 16'h1018
`define ODP_IDX_RXMAP 16'h1600
`define ODP_IDX_TXMAP 16'h1A00
`define ODP_SUB_SAVE 8'h03
`define ODP_SUB_IDMAX 8'h04
`define ODP_DEVTYPE_VAL 32'h0002_0192
`define ODP_ERRSUM_MASK 8'hBF
`define ODP_HIST_DEPTH 8
`define ODP_SAVE_SIG 32'h6576_6173
`define ODP_STORE_CAPS 32'h0000_0002
`define ODP_IDENT_CNT 32'h0000_0004
`define ODP_SAVE_NUM 7
`define ODP_SAVE_KEYS '{24'h609A00, 24'h609902, 24'h609901, \
   24'h609800, 24'h609302, 24'h609301, 24'h607C00}
`define ODP_MAP_DEPTH 8
`define ODP_MAP_BITS 256
`define ODP_MAP_LEN_HI 7
`define ODP_MAP_LEN_LO 0
`define ODP_ESM_PREOP 4'h2
`define ODP_AB_RO 32'h0601_0002
`define ODP_AB_NOOBJ 32'h0602_0000
`define ODP_AB_LEN 32'h0604_0042
`define ODP_AB_NOSUB 32'h0609_0011
`define ODP_AB_STORE 32'h0800_0020
`define ODP_AB_STATE 32'h0800_0022
`define ODP_E_RCTL 32'h6040_0010
`define ODP_E_RTPOS 32'h60FF_0020
`define ODP_E_RPRB 32'h60B8_0010
`define ODP_E_RDOUT 32'h60FE_0120
`define ODP_E_TSTS 32'h6041_0010
`define ODP_E_TVEL 32'h606C_0020
`define ODP_E_TTRQ 32'h6077_0010
`define ODP_E_TPOS 32'h6064_0020
`define ODP_E_TERR 32'h60F4_0020
`define ODP_E_TPST 32'h60B9_0010
`define ODP_E_TPP1 32'h60BA_0020
`define ODP_E_TPP2 32'h60BC_0020
`define ODP_E_TDIN 32'h60FD_0020

`endif

// [design/odp_pkg.sv]
package odp_pkg;
   typedef struct packed {
      logic valid;
      logic write;
      logic [15:0] index;
      logic [7:0] sub;
      logic [31:0] wdata;
   } odp_req_s;
   typedef struct packed {
      logic valid;
      logic abort;
      logic [31:0] data;
   } odp_rsp_s;
   typedef struct packed {
      logic valid;
      logic [15:0] emcy;
      logic [15:0] alarm;
   } odp_alarm_s;
   typedef logic [6:0][31:0] odp_params_t;
   typedef logic [7:0][31:0] odp_ents_t;
   typedef enum logic {ST_LOAD, ST_RUN} odp_phase_e;
endpackage

// [design/odp_pdo_map.sv]
`timescale 1ns/1ps
`include "odp_map.svh"
module odp_pdo_map #(
   parameter logic [7:0] DEF_CNT = 8'h00,
   parameter odp_pkg::odp_ents_t DEF_ENT = '0,
   parameter int MAX_ENT = `ODP_MAP_DEPTH,
   parameter int MAX_BITS = `ODP_MAP_BITS
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic sel,
   input wire logic write,
   input wire logic preop,
   input wire logic [7:0] sub,
   input wire logic [31:0] wdata,
   output logic [31:0] rdata,
   output logic [31:0] code
);
   import odp_pkg::*;
   logic [7:0] cnt_reg;
   odp_ents_t ent_reg;
   logic [11:0] len_sum;
   logic [2:0] ent_sel;
   logic sub_ok;
   logic too_big;

   assign sub_ok = sub <= 8'(MAX_ENT);
   assign ent_sel = 3'(sub - 8'h01);
   always_comb begin
      len_sum = '0;
      for (int i = 0; i < MAX_ENT; i++) begin
         if (32'(i) < wdata)
            len_sum = len_sum +
               12'(ent_reg[i][`ODP_MAP_LEN_HI:`ODP_MAP_LEN_LO]);
      end
   end
   assign too_big = wdata > 32'(MAX_ENT) || len_sum > 12'(MAX_BITS);
   assign code = !sub_ok ? `ODP_AB_NOSUB :
                 (write && !preop) ? `ODP_AB_STATE :
                 (write && sub == 8'h00 && too_big) ? `ODP_AB_LEN :
                 32'h0000_0000;
   assign rdata = (sub == 8'h00) ? {24'h000000, cnt_reg} : ent_reg[ent_sel];

   ////////////////////////////////////////////////////////////////
   // storage only changes on accepted writes
   always_ff @(posedge clk) begin
      if (!rstn) begin
         cnt_reg <= DEF_CNT;
         ent_reg <= DEF_ENT;
      end else if (sel && write && code == 32'h0000_0000) begin
         if (sub == 8'h00)
            cnt_reg <= wdata[7:0];
         else
            ent_reg[ent_sel] <= wdata;
      end
   end

   ////////////////////////////////////////////////////////////////
   a_map_count: assert property (@(posedge clk) disable iff (!rstn)
      cnt_reg <= 8'(MAX_ENT))
      else $error("mapping count above limit");
   a_map_gate: assert property (@(posedge clk) disable iff (!rstn)
      sel && write && !preop |=> $stable(cnt_reg) && $stable(ent_reg))
      else $error("mapping changed outside pre-operational");
endmodule

// [tb/odp_master.sv]
`timescale 1ns/1ps
module odp_master (
   input wire logic clk,
   output odp_pkg::odp_req_s req,
   input odp_pkg::odp_rsp_s rsp
);
   import odp_pkg::*;
   odp_rsp_s got;
   logic pre_ab;
   initial begin
      req = '0;
      got = '0;
      pre_ab = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////
   // Taken at the rising edge between two falling edges, answer one later
   task automatic access(input logic w, input logic [15:0] idx,
      input logic [7:0] sb, input logic [31:0] wd);
      @(negedge clk);
      req <= '{valid: 1'b1, write: w, index: idx, sub: sb, wdata: wd};
      @(negedge clk);
      // Answer stands only until the next rising edge
      got = rsp;
      // Released fields flip so a stale value never looks valid
      req <= '{valid: 1'b0, write: ~w, index: ~idx, sub: ~sb, wdata: ~wd};
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Signature, LSB first
   task automatic save();
      access(1'b1, 16'h1010, 8'h03, 32'h6576_6173);
   endtask
   // Count off, entries, count last; caller sets n and length
   // Sync-manager assignment lives outside this block
   task automatic remap(input logic [15:0] idx, input logic [7:0] n,
      input logic [31:0] ent);
      pre_ab = 1'b0;
      access(1'b1, idx, 8'h00, 32'h0);
      pre_ab = pre_ab | got.abort;
      for (int i = 1; i <= n; i++) begin
         access(1'b1, idx, i[7:0], ent);
         pre_ab = pre_ab | got.abort;
      end
      access(1'b1, idx, 8'h00, {24'h0, n});
   endtask
endmodule

// [tb/fieldbus_object_dictionary_tb.sv]
`timescale 1ns/1ps
`include "odp_map.svh"
module fieldbus_object_dictionary_tb;
   import odp_pkg::*;
   logic clk;
   logic rstn;
   logic servo_on;
   logic [3:0] net_state;
   logic [7:0] err_flags;
   logic [7:0] err_sum;
   logic nv_store;
   odp_req_s req;
   odp_rsp_s rsp;
   odp_alarm_s alarm;
   odp_params_t nv_in;
   odp_params_t nv_out;
   int n_fail;
   int n_compared;
   logic [23:0] keys [7] = '{24'h609A00, 24'h609902, 24'h609901,
      24'h609800, 24'h609302, 24'h609301, 24'h607C00};
   logic [15:0] maps [8] = '{16'h1600, 16'h1601, 16'h1602, 16'h1603,
      16'h1A00, 16'h1A01, 16'h1A02, 16'h1A03};
   logic [7:0] cnts [8] = '{8'h2, 8'h2, 8'h4, 8'h1, 8'h3, 8'h3, 8'h8, 8'h1};
   logic [31:0] ids [5] = '{32'h4, 32'h123, 32'h456, 32'h0001_0000, 32'h0};

   odp_dictionary u_dut (.CORE_CLK(clk), .RSTN(rstn), .REQ(req),
      .RSP(rsp), .SERVO_ON(servo_on), .NET_STATE(net_state),
      .ERR_FLAGS(err_flags), .ALARM(alarm), .NV_PARAMS_IN(nv_in),
      .NV_STORE(nv_store), .NV_PARAMS_OUT(nv_out), .ERR_SUMMARY(err_sum));
   odp_master u_mst (.clk(clk), .req(req), .rsp(rsp));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   function automatic logic [31:0] va();
      return {30'h0, u_mst.got.valid, u_mst.got.abort};
   endfunction
   task automatic rd(input logic [15:0] i, input logic [7:0] s,
      input logic [31:0] e);
      u_mst.access(1'b0, i, s, 32'h0);
      cmp(va(), 32'h2);
      cmp(u_mst.got.data, e);
   endtask
   task automatic wr(input logic [15:0] i, input logic [7:0] s,
      input logic [31:0] d);
      u_mst.access(1'b1, i, s, d);
      cmp(va(), 32'h2);
      cmp(u_mst.got.data, 32'h0);
   endtask
   task automatic ab(input logic w, input logic [15:0] i,
      input logic [7:0] s, input logic [31:0] d, input logic [31:0] c);
      u_mst.access(w, i, s, d);
      cmp(va(), 32'h3);
      cmp(u_mst.got.data, c);
   endtask
   task automatic pulse(input logic [15:0] a);
      @(negedge clk);
      alarm <= '{valid: 1'b1, emcy: 16'h8000 + a, alarm: a};
      @(negedge clk);
      alarm.valid <= 1'b0;
   endtask
   task automatic close_out();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #500000;
      n_fail++;
      $display("mismatch at %0t: watchdog expired", $time);
      close_out();
   end
   initial begin
      rstn = 1'b0;
      servo_on = 1'b0;
      net_state = 4'h0;
      err_flags = 8'hFF;
      alarm = '0;
      for (int i = 0; i < 7; i++) begin
         nv_in[i] = 32'hA000_0000 + i;
      end
      repeat (16) @(negedge clk);
      rstn = 1'b1;
      repeat (2) @(negedge clk);
      rd(16'h1000, 8'h00, `ODP_DEVTYPE_VAL);
      rd(16'h1001, 8'h00, 32'hBF);
      cmp({24'h0, err_sum}, 32'hBF);
      err_flags = 8'h41;
      rd(16'h1001, 8'h00, 32'h01);
      ab(1'b1, 16'h1001, 8'h00, 32'h0, `ODP_AB_RO);
      ab(1'b0, 16'h1002, 8'h00, 32'h0, `ODP_AB_NOOBJ);
      ab(1'b0, 16'h1018, 8'h05, 32'h0, `ODP_AB_NOSUB);
      // Identity values here are arbitrary
      for (int i = 0; i < 5; i++) begin
         rd(16'h1018, i[7:0], ids[i]);
      end
      rd(16'h1010, 8'h00, 32'h3);
      rd(16'h1010, 8'h01, 32'h0);
      rd(16'h1010, 8'h03, 32'h2);
      for (int k = 0; k < 7; k++) begin
         rd(keys[k][23:8], keys[k][7:0], nv_in[k]);
      end
      wr(16'h607C, 8'h00, 32'h1234_5678);
      // Synchroniser needs a few edges to see the motor state
      servo_on = 1'b1;
      repeat (4) @(negedge clk);
      ab(1'b1, 16'h1010, 8'h03, 32'h6576_6173, `ODP_AB_STATE);
      cmp({31'h0, nv_store}, 32'h0);
      servo_on = 1'b0;
      repeat (4) @(negedge clk);
      ab(1'b1, 16'h1010, 8'h03, 32'h7361_7665, `ODP_AB_STORE);
      cmp({31'h0, nv_store}, 32'h0);
      u_mst.save();
      cmp(va(), 32'h2);
      cmp({31'h0, nv_store}, 32'h1);
      cmp(nv_out[6], 32'h1234_5678);
      cmp(nv_out[0], nv_in[0]);
      pulse(16'h0001);
      rd(16'h1003, 8'h00, 32'h0);
      servo_on = 1'b1;
      repeat (4) @(negedge clk);
      for (int a = 1; a <= 9; a++) begin
         pulse(a[15:0]);
      end
      rd(16'h1003, 8'h00, 32'h8);
      rd(16'h1003, 8'h01, 32'h8009_0009);
      rd(16'h1003, 8'h08, 32'h8002_0002);
      ab(1'b1, 16'h1003, 8'h01, 32'h0, `ODP_AB_RO);
      servo_on = 1'b0;
      for (int m = 0; m < 8; m++) begin
         rd(maps[m], 8'h00, {24'h0, cnts[m]});
      end
      rd(16'h1600, 8'h01, `ODP_E_RCTL);
      rd(16'h1A02, 8'h08, `ODP_E_TDIN);
      net_state = 4'h8;
      ab(1'b1, 16'h1600, 8'h00, 32'h0, `ODP_AB_STATE);
      ab(1'b1, 16'h1A00, 8'h01, 32'h0, `ODP_AB_STATE);
      rd(16'h1600, 8'h00, 32'h2);
      net_state = `ODP_ESM_PREOP;
      u_mst.remap(16'h1600, 8'h8, 32'h60FF_0020);
      cmp({31'h0, u_mst.pre_ab}, 32'h0);
      cmp(va(), 32'h2);
      rd(16'h1600, 8'h00, 32'h8);
      rd(16'h1600, 8'h08, 32'h60FF_0020);
      ab(1'b1, 16'h1600, 8'h00, 32'h9, `ODP_AB_LEN);
      // Length byte 28h: eight 40-bit entries, 320 bits, subindex byte zero
      u_mst.remap(16'h1A03, 8'h8, 32'h60BA_0028);
      cmp(va(), 32'h3);
      cmp(u_mst.got.data, `ODP_AB_LEN);
      rd(16'h1A03, 8'h00, 32'h0);
      rd(16'h1A03, 8'h08, 32'h60BA_0028);
      close_out();
   end
endmodule
